// *** design/cw_defines.vh ***
`ifndef CW_DEFINES_VH
`define CW_DEFINES_VH

// Register indices; the byte address is four times the index
`define IDX_TRX_STATUS      6'h01
`define IDX_STATE_COMMAND   6'h02
`define IDX_TX_POWER        6'h05
`define IDX_CHANNEL         6'h08
`define IDX_IRQ_MASK        6'h0e
`define IDX_IRQ_STATUS      6'h0f
`define IDX_TEST_MODE       6'h1c
`define IDX_TEST_CONFIG_A   6'h34
`define IDX_TEST_CONFIG_B   6'h36
`define IDX_TEST_CONFIG_C   6'h3f

// State command values
`define CMD_TX_START        8'h02
`define CMD_RADIO_IDLE      8'h03
`define CMD_PLL_ON          8'h09

// Status codes shown in transceiver_status
`define STS_RADIO_IDLE      8'h08
`define STS_PLL_ON          8'h09
`define STS_BUSY_TX         8'h02
`define STS_IN_TRANSITION   8'h1f

// Test mode control values
`define TM_ARM_FIRST        8'h54
`define TM_ARM_SECOND       8'h42
`define TM_DISABLE          8'h00

// Interrupt bit positions
`define IRQ_PLL_LOCK        0
`define IRQ_CW_START        1
`define IRQ_CW_STOP         2

// tx_gain_offset and power level fields in the power register
`define GAIN_OFFS_LSB       5
`define GAIN_OFFS_MSB       6
`define POWER_LEVEL_MSB     3

// Reset values
`define RST_IRQ_MASK        8'h00
`define RST_TX_POWER        8'h00
`define RST_CHANNEL         8'h00
`define RST_TEST_MODE       8'h00

`endif

// *** design/reg_byte_mem.v ***
`timescale 1ns/1ps
module reg_byte_mem
(
    input  wire       mclk,  // System clock
    input  wire       ce,    // Clock enable
    input  wire       we,    // Write strobe
    input  wire [5:0] addr,  // Word index
    input  wire [7:0] wdata, // Write data
    output reg  [7:0] rdata  // Registered read data
);
    reg [7:0] mem [0:63];

    // No reset on the array; software sees whatever it last wrote
    always @(posedge mclk)
    begin
        if (ce)
        begin
            if (we)
                mem[addr] <= wdata;
            rdata <= mem[addr];
        end
    end
endmodule // reg_byte_mem

// *** design/cw_test_mode_sequencer.v ***
// Notes on behaviour
// - command 0x03 gives idle, status reads 0x08
// - command 0x09 locks PLL, flags lock event
// - command 0x02 after lock, with test mode armed by 0x54 then 0x42, starts continuous transmission
// - writing 0x00 to test mode stops transmission
//
// The implementer's own choice: register access over Wishbone.
`timescale 1ns/1ps
`include "cw_defines.vh"
module cw_test_mode_sequencer
(
    input  wire        mclk,           // 200 MHz clock
    input  wire        rstn,           // Async reset, active low
    input  wire        ce,             // Clock enable
    input  wire [9:0]  wb_adr_i,       // Byte address
    input  wire [31:0] wb_dat_i,       // Write data
    input  wire [3:0]  wb_sel_i,       // Byte enables
    input  wire        wb_we_i,        // Write enable
    input  wire        wb_cyc_i,       // Cycle
    input  wire        wb_stb_i,       // Strobe
    output reg  [31:0] wb_dat_o,       // Read data
    output reg         wb_ack_o,       // Acknowledge
    input  wire        pll_lock,       // PLL lock indication, asynchronous
    output reg         pll_enable,     // Request the PLL to run
    output reg         cw_active,      // Continuous carrier on air
    output reg  [1:0]  tx_gain_offset, // Gain offset field
    output reg  [3:0]  tx_power_level, // Output power level
    output reg  [7:0]  channel,        // Channel number
    output reg         irq             // Level interrupt
);
    localparam [3:0] ST_IDLE     = 4'h1;
    localparam [3:0] ST_PLL_WAIT = 4'h2;
    localparam [3:0] ST_PLL_ON   = 4'h4;
    localparam [3:0] ST_BUSY_TX  = 4'h8;

    reg  [3:0] state;
    reg  [3:0] next_state;
    reg        pend;
    reg  [5:0] idx;
    reg        lock_meta;
    reg        lock_sync;
    reg  [7:0] irq_mask;
    reg  [7:0] irq_status;
    reg  [7:0] next_irq_status;
    reg  [7:0] tx_power;
    reg  [7:0] test_mode;
    reg        arm_first;
    reg        armed;
    reg  [7:0] irq_set;
    reg  [7:0] rd_sel;
    wire [7:0] mem_rdata;
    wire       req;
    wire       wr;
    wire       hi_ok;
    wire [7:0] wbyte;

    function [7:0] status_code;
        input [3:0] st;
        begin
            case (st)
                ST_IDLE:     status_code = `STS_RADIO_IDLE;
                ST_PLL_ON:   status_code = `STS_PLL_ON;
                ST_BUSY_TX:  status_code = `STS_BUSY_TX;
                default:     status_code = `STS_IN_TRANSITION;
            endcase
        end
    endfunction

    function is_reg;
        input [5:0] a;
        input [5:0] target;
        begin
            is_reg = (a == target);
        end
    endfunction

    // New request only when idle, so a held request is taken once
    assign req   = wb_cyc_i & wb_stb_i & ~pend & ~wb_ack_o;
    assign hi_ok = (wb_adr_i[9:8] == 2'b00);
    // Write lands on the edge that raises ack
    assign wr    = pend & wb_we_i & wb_sel_i[0] & hi_ok;
    assign wbyte = wb_dat_i[7:0];

    reg_byte_mem u_mem
    (
        .mclk  (mclk),
        .ce    (ce),
        .we    (wr),
        .addr  (wb_adr_i[7:2]),
        .wdata (wbyte),
        .rdata (mem_rdata)
    );

    // Lock comes from the analog side; two stages before any use
    always @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
        begin
            lock_meta <= 1'b0;
            lock_sync <= 1'b0;
        end
        else if (ce)
        begin
            lock_meta <= pll_lock;
            lock_sync <= lock_meta;
        end
    end

    always @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
        begin
            pend     <= 1'b0;
            wb_ack_o <= 1'b0;
            idx      <= 6'h00;
        end
        else if (ce)
        begin
            pend     <= req;
            wb_ack_o <= pend;
            if (req)
                idx <= wb_adr_i[7:2];
        end
    end

    always @*
    begin
        case (idx)
            `IDX_TRX_STATUS:  rd_sel = status_code(state);
            `IDX_IRQ_MASK:    rd_sel = irq_mask;
            `IDX_IRQ_STATUS:  rd_sel = irq_status;
            `IDX_TX_POWER:    rd_sel = tx_power;
            `IDX_CHANNEL:     rd_sel = channel;
            `IDX_TEST_MODE:   rd_sel = test_mode;
            default:          rd_sel = mem_rdata;
        endcase
    end

    always @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
            wb_dat_o <= 32'h0000_0000;
        else if (ce)
        begin
            if (pend)
                wb_dat_o <= {24'h00_0000, (hi_ok ? rd_sel : 8'h00)};
            else
                wb_dat_o <= 32'h0000_0000;
        end
    end

    // Radio state machine
    always @*
    begin
        next_state = state;
        irq_set    = 8'h00;
        case (state)
            ST_IDLE:
            begin
                if (wr && is_reg(wb_adr_i[7:2], `IDX_STATE_COMMAND)
                    && wbyte == `CMD_PLL_ON)
                    next_state = ST_PLL_WAIT;
            end
            ST_PLL_WAIT:
            begin
                if (wr && is_reg(wb_adr_i[7:2], `IDX_STATE_COMMAND)
                    && wbyte == `CMD_RADIO_IDLE)
                    next_state = ST_IDLE;
                else if (lock_sync)
                begin
                    next_state              = ST_PLL_ON;
                    irq_set[`IRQ_PLL_LOCK]  = 1'b1;
                end
            end
            ST_PLL_ON:
            begin
                if (wr && is_reg(wb_adr_i[7:2], `IDX_STATE_COMMAND)
                    && wbyte == `CMD_RADIO_IDLE)
                    next_state = ST_IDLE;
                else if (!lock_sync)
                    next_state = ST_PLL_WAIT;
                else if (wr && is_reg(wb_adr_i[7:2], `IDX_STATE_COMMAND)
                         && wbyte == `CMD_TX_START && armed)
                begin
                    next_state             = ST_BUSY_TX;
                    irq_set[`IRQ_CW_START] = 1'b1;
                end
            end
            ST_BUSY_TX:
            begin
                // Carrier runs until the test mode is switched off or the radio-idle command 0x03 is written
                if (wr && is_reg(wb_adr_i[7:2], `IDX_TEST_MODE)
                    && wbyte == `TM_DISABLE)
                begin
                    next_state            = ST_PLL_ON;
                    irq_set[`IRQ_CW_STOP] = 1'b1;
                end
                else if (wr && is_reg(wb_adr_i[7:2], `IDX_STATE_COMMAND)
                         && wbyte == `CMD_RADIO_IDLE)
                begin
                    next_state            = ST_IDLE;
                    irq_set[`IRQ_CW_STOP] = 1'b1;
                end
            end
            default:
                next_state = ST_IDLE;
        endcase
    end

    always @*
    begin
        next_irq_status = irq_status;
        if (wr && is_reg(wb_adr_i[7:2], `IDX_IRQ_STATUS))
            next_irq_status = irq_status & ~wbyte;
        // Set after clear so an event in the clearing cycle survives
        next_irq_status = next_irq_status | irq_set;
    end

    always @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
        begin
            state      <= ST_IDLE;
            irq_status <= 8'h00;
            irq_mask   <= `RST_IRQ_MASK;
            tx_power   <= `RST_TX_POWER;
            channel    <= `RST_CHANNEL;
            test_mode  <= `RST_TEST_MODE;
            arm_first  <= 1'b0;
            armed      <= 1'b0;
        end
        else if (ce)
        begin
            state      <= next_state;
            irq_status <= next_irq_status;
            if (wr && is_reg(wb_adr_i[7:2], `IDX_IRQ_MASK))
                irq_mask <= wbyte;
            if (wr && is_reg(wb_adr_i[7:2], `IDX_CHANNEL))
                channel <= wbyte;
            // Power is locked while the carrier is on air
            if (wr && is_reg(wb_adr_i[7:2], `IDX_TX_POWER) && state != ST_BUSY_TX)
                tx_power <= wbyte;
            if (wr && is_reg(wb_adr_i[7:2], `IDX_TEST_MODE))
            begin
                test_mode <= wbyte;
                // The two-step write arms the carrier; 0x42 again keeps it armed, any other value disarms
                arm_first <= (wbyte == `TM_ARM_FIRST);
                armed     <= (wbyte == `TM_ARM_SECOND) && (arm_first || armed);
            end
        end
    end

    // Outputs all from flops
    always @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
        begin
            pll_enable     <= 1'b0;
            cw_active      <= 1'b0;
            tx_gain_offset <= 2'b00;
            tx_power_level <= 4'h0;
            irq            <= 1'b0;
        end
        else if (ce)
        begin
            pll_enable     <= (next_state != ST_IDLE);
            cw_active      <= (next_state == ST_BUSY_TX);
            tx_gain_offset <= tx_power[`GAIN_OFFS_MSB:`GAIN_OFFS_LSB];
            tx_power_level <= tx_power[`POWER_LEVEL_MSB:0];
            irq            <= |(next_irq_status & irq_mask);
        end
    end
endmodule // cw_test_mode_sequencer

// *** bench/cw_seq_checker.sv ***
`timescale 1ns/1ps
module cw_seq_checker
(
    input wire        mclk,           // Clock
    input wire        rstn,           // Reset
    input wire        ce,             // Enable
    input wire [9:0]  wb_adr_i,       // Address
    input wire [31:0] wb_dat_i,       // Wdata
    input wire [3:0]  wb_sel_i,       // Lanes
    input wire        wb_we_i,        // Write
    input wire        wb_cyc_i,       // Cycle
    input wire        wb_stb_i,       // Strobe
    input wire [31:0] wb_dat_o,       // Rdata
    input wire        wb_ack_o,       // Ack
    input wire        pll_lock,       // Lock
    input wire        pll_enable,     // PLL run
    input wire        cw_active,      // Carrier
    input wire [1:0]  tx_gain_offset, // Gain
    input wire [3:0]  tx_power_level, // Power
    input wire [7:0]  channel,        // Channel
    input wire        irq             // Interrupt
);
    default clocking @(posedge mclk); endclocking
    default disable iff (!rstn);
    wire st_wr = wb_ack_o && wb_we_i && wb_sel_i[0] && wb_adr_i == 10'h008;
    wire tx_wr = st_wr && wb_dat_i[7:0] == 8'h02;
    wire off_wr = wb_ack_o && wb_we_i && wb_sel_i[0] && wb_adr_i == 10'h070;
    sequence s_req; $rose(wb_stb_i) && wb_cyc_i && ce ##1 ce [*2]; endsequence
    // The carrier flop has already dropped by the ack edge, so look one cycle back
    sequence s_stop; off_wr && wb_dat_i[7:0] == 8'h00 && $past(cw_active); endsequence
    property p_ack_time; s_req |-> wb_ack_o; endproperty
    a_ack_time: assert property (p_ack_time) else $error("ack late");
    property p_ack_pulse; wb_ack_o |=> !wb_ack_o; endproperty
    a_ack_pulse: assert property (p_ack_pulse) else $error("ack too long");
    property p_dat_idle; !wb_ack_o |-> wb_dat_o == 32'h0; endproperty
    a_dat_idle: assert property (p_dat_idle) else $error("data outside ack");
    property p_unmapped; wb_ack_o && !wb_we_i && wb_adr_i[9:8] != 2'h0 |-> wb_dat_o == 32'h0;
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
    property p_idle_cmd; st_wr && wb_dat_i[7:0] == 8'h03 |-> ##[0:3] !pll_enable; endproperty
    a_idle_cmd: assert property (p_idle_cmd) else $error("idle not entered");
    property p_pll_cmd; st_wr && wb_dat_i[7:0] == 8'h09 && !cw_active |-> ##[0:3] pll_enable;
    endproperty
    a_pll_cmd: assert property (p_pll_cmd) else $error("pll not started");
    // The write lands on the edge that raises ack, so the carrier rises as ack is seen
    property p_tx_start; $rose(cw_active) |-> tx_wr; endproperty
    a_tx_start: assert property (p_tx_start) else $error("carrier without command");
    property p_power_hold; cw_active && $past(cw_active) |-> $stable(tx_power_level)
        && $stable(tx_gain_offset); endproperty
    a_power_hold: assert property (p_power_hold) else $error("power moved in carrier");
    property p_stop; s_stop |-> ##[0:3] !cw_active; endproperty
    a_stop: assert property (p_stop) else $error("carrier not stopped");
endmodule // cw_seq_checker

bind cw_test_mode_sequencer cw_seq_checker i_cw_seq_checker (.*);

// *** bench/pll_model.sv ***
`timescale 1ns/1ps
module pll_model
#(
    parameter LOCK_CYCLES = 20 // Lock time, plain default
)
(
    input  wire  mclk,       // Clock
    input  wire  pll_enable, // Run request
    output logic pll_lock    // Lock level
);
    int cnt = 0;
    initial pll_lock = 1'b0;
    // Lock only after a settling time, so the waiting state is seen
    always @(posedge mclk)
    begin
        cnt <= pll_enable ? cnt + 1 : 0;
        pll_lock <= pll_enable && cnt >= LOCK_CYCLES;
    end
endmodule // pll_model

// *** bench/cw_test_mode_sequencer_test.sv ***
`timescale 1ns/1ps
module cw_test_mode_sequencer_test;
    logic        mclk = 0;
    logic        rstn = 0;
    logic        ce = 1;
    logic        wb_we_i = 0;
    logic        wb_cyc_i = 0;
    logic        wb_stb_i = 0;
    logic [9:0]  wb_adr_i = 0;
    logic [31:0] wb_dat_i = 0;
    logic [3:0]  wb_sel_i = 0;
    wire  [31:0] wb_dat_o;
    wire         wb_ack_o, pll_lock, pll_enable, cw_active, irq;
    wire  [1:0]  tx_gain_offset;
    wire  [3:0]  tx_power_level;
    wire  [7:0]  channel;
    int          fails = 0;
    int          num_checks = 0;
    int          cycles = 0;
    logic [31:0] lfsr = 32'd83966;
    logic [7:0]  expq[$];
    logic [7:0]  ch, pw;
    cw_test_mode_sequencer i_cw_test_mode_sequencer (.*);
    pll_model i_pll_model (.*);
    initial forever #2.5 mclk = ~mclk;
    function logic [31:0] next_rand(input logic [31:0] v);
        return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction
    task check(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp)
        begin
            fails++;
            $display("BAD %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task finish_test;
        $display("checks %0d fails %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    // Reads note their expectation; the watcher below compares on ack
    task wb(input logic w, input logic [9:0] a, input logic [7:0] d, input logic [7:0] e);
        if (!w) expq.push_back(e);
        @(posedge mclk);
        {wb_cyc_i, wb_stb_i, wb_we_i, wb_sel_i} <= {2'b11, w, 4'h1};
        {wb_adr_i, wb_dat_i} <= {a, 24'h0, d};
        do @(negedge mclk); while (wb_ack_o !== 1'b1);
        @(posedge mclk);
        {wb_cyc_i, wb_stb_i, wb_we_i} <= 3'b000;
    endtask
    task waitn(input int n);
        repeat (n) @(negedge mclk);
    endtask
    always @(posedge mclk)
    begin
        cycles++;
        if (cycles > 5000)
        begin
            fails++;
            finish_test;
        end
        if (wb_ack_o === 1'b1 && wb_we_i === 1'b0) check(wb_dat_o, {24'h0, expq.pop_front()});
    end
    initial
    begin
        repeat (8) @(posedge mclk);
        rstn <= 1;
        waitn(1);
        check({cw_active, pll_enable, irq, tx_gain_offset, tx_power_level, channel}, 0);
        lfsr = next_rand(lfsr);
        ch = lfsr[7:0];
        pw = {3'b011, 1'b0, lfsr[11:8]};
        wb(1, 10'h038, 8'h01, 0);
        wb(0, 10'h038, 0, 8'h01);
        wb(1, 10'h008, 8'h03, 0);
        wb(1, 10'h020, ch, 0);
        wb(1, 10'h014, pw, 0);
        wb(0, 10'h004, 0, 8'h08);
        waitn(1);
        check({pll_enable, channel, tx_gain_offset, tx_power_level}, {1'b0, ch, 2'h3, pw[3:0]});
        wb(1, 10'h0d8, 8'h0f, 0);
        wb(1, 10'h070, 8'h54, 0);
        wb(1, 10'h070, 8'h42, 0);
        wb(1, 10'h0d0, 8'h00, 0);
        wb(1, 10'h0fc, 8'h08, 0);
        wb(1, 10'h008, 8'h09, 0);
        wb(0, 10'h004, 0, 8'h1f);
        while (irq !== 1'b1) @(negedge mclk);
        wb(0, 10'h03c, 0, 8'h01);
        wb(0, 10'h004, 0, 8'h09);
        wb(1, 10'h008, 8'h02, 0);
        wb(0, 10'h004, 0, 8'h02);
        wb(1, 10'h014, ~pw, 0);
        waitn(1);
        check({cw_active, tx_gain_offset, tx_power_level}, {1'b1, 2'h3, pw[3:0]});
        wb(0, 10'h03c, 0, 8'h03);
        wb(1, 10'h03c, 8'h01, 0);
        waitn(2);
        check(irq, 0);
        wb(1, 10'h070, 8'h00, 0);
        waitn(2);
        check(cw_active, 0);
        wb(0, 10'h004, 0, 8'h09);
        wb(0, 10'h104, 0, 8'h00);
        @(posedge mclk);
        rstn <= 0;
        repeat (2) @(posedge mclk);
        rstn <= 1;
        waitn(1);
        check({cw_active, pll_enable, irq, tx_gain_offset, tx_power_level}, 0);
        finish_test;
    end
endmodule // cw_test_mode_sequencer_test
